// *** rtl/uth_pkg.sv ***
// package: register map, field layout, timing counts and types of the tx path
package uth_pkg;

  // register offsets on the 3-bit host address
  localparam logic [2:0] UTH_OFF_HOLD = 3'h0; // tx holding / divisor low
  localparam logic [2:0] UTH_OFF_IEN = 3'h1; // irq enable / divisor high
  localparam logic [2:0] UTH_OFF_LCTL = 3'h3; // line control
  localparam logic [2:0] UTH_OFF_MCTL = 3'h4; // modem control (loop bit)
  localparam logic [2:0] UTH_OFF_LSTAT = 3'h5; // line status
  localparam logic [2:0] UTH_OFF_SCRATCH = 3'h7; // scratchpad

  // line control fields
  localparam int UTH_LC_WLEN_LO = 0; // word length select, 2 bits
  localparam int UTH_LC_STOP = 2; // extra stop bits
  localparam int UTH_LC_PEN = 3; // parity enable
  localparam int UTH_LC_EVEN = 4; // even parity select
  localparam int UTH_LC_STICK = 5; // stick parity
  localparam int UTH_LC_BREAK = 6; // force line low
  localparam int UTH_LC_DLAB = 7; // divisor latch access
  localparam int UTH_IE_TX_HOLDING_EMPTY = 1; // holding-empty irq enable bit
  localparam int UTH_MC_LOOP = 4; // loop diagnostic mode bit
  localparam int UTH_LS_TX_HOLDING_EMPTY = 5; // holding empty status bit
  localparam int UTH_LS_TEMT = 6; // transmitter empty status bit

  // reset values
  localparam logic [7:0] UTH_RST_BYTE = 8'h00; // all control registers
  localparam logic [15:0] UTH_RST_DIV = 16'h0000; // divisor, baud halted

  // timing counts in 16x baud ticks
  localparam logic [5:0] UTH_TICKS_BIT = 6'h10; // one serial bit
  localparam logic [5:0] UTH_TICKS_STOP15 = 6'h18; // one and a half stops
  localparam logic [5:0] UTH_TICKS_STOP2 = 6'h20; // two stop bits
  localparam logic [3:0] UTH_WLEN_BASE = 4'h5; // shortest word length

  // transmitter sequence, one-hot
  typedef enum logic [4:0] {
    UTH_ST_IDLE = 5'h01,
    UTH_ST_START = 5'h02,
    UTH_ST_DATA = 5'h04,
    UTH_ST_PARITY = 5'h08,
    UTH_ST_STOP = 5'h10
  } uth_tx_state_type;

  // one host register access
  typedef struct packed {
    logic wr; // write strobe, one cycle
    logic rd; // read strobe, one cycle
    logic [2:0] addr; // register offset
    logic [7:0] wdata; // write data
  } uth_host_req_type;

endpackage

// *** rtl/uth_baud_gen.sv ***
// baud generator: 16-bit divider producing the 16x tick enable
`timescale 1ns/1ps
module uth_baud_gen (
  input wire logic clk, // system clock
  input wire logic reset, // synchronous, active high
  input wire logic load, // divisor byte written, reload now
  input wire logic [15:0] divisor, // divisor value to use
  output logic tick // one-cycle 16x baud enable
);
  import uth_pkg::*;

  logic [15:0] cnt_r; // down counter
  logic [15:0] cnt_nxt;
  logic tick_r; // registered tick
  logic tick_nxt;

  // next count: reload on write, else count down and wrap
  always_comb begin
    cnt_nxt = cnt_r;
    tick_nxt = 1'b0;
    if (load) begin
      cnt_nxt = divisor; // see RQ9
    end else if (divisor == UTH_RST_DIV) begin
      cnt_nxt = UTH_RST_DIV; // zero divisor halts the clock
    end else if (cnt_r <= 16'h0001) begin
      cnt_nxt = divisor;
      tick_nxt = 1'b1; // see RQ8
    end else begin
      cnt_nxt = cnt_r - 16'h0001;
    end
  end

  // register the counter
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_r <= UTH_RST_DIV;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;

  // reload takes the new divisor at once
  chk_div_reload: assert property (@(posedge clk) disable iff (reset) // see RQ9
    load |=> cnt_r == $past(divisor))
    else $error("baud counter not reloaded on divisor write");

endmodule

// *** rtl/uth_tx_holding.sv ***
// transmit holding path, line control and scratchpad of one serial channel
`timescale 1ns/1ps
// Behaviour
// RQ1: scratchpad byte, readable, affects nothing else
// RQ2: transmitter timed only by baud ticks; leaving idle here does not wait for a tick
// RQ3: line control sets length, parity, stops
// RQ4: holding byte moves only when shifter idle
// RQ5: shifter sends character bit by bit
// RQ6: holding empty and enabled raises interrupt
// RQ7: loading a character clears the interrupt
// RQ8: sixteen baud ticks per serial bit
// RQ9: divisor byte write reloads baud counter
// RQ10: loop mode: output high, shifter to receiver
// RQ11: low start, lsb first, parity, high stops
module uth_tx_holding (
  input wire logic clk, // system clock, 250 MHz
  input wire logic reset, // synchronous, active high
  input wire uth_pkg::uth_host_req_type host_req, // register access
  output logic [7:0] rdata, // read data, registered
  output logic serial_out, // serial line, registered
  output logic loop_data, // shifter output to receiver in loop
  output logic baud_tick_clock, // 16x baud enable pulse
  output logic tx_empty_irq // holding-empty interrupt request
);
  import uth_pkg::*;

  // host-visible registers
  logic [7:0] scratchpad_r, scratchpad_nxt; // free byte for software
  logic [7:0] tx_holding_reg_r, tx_holding_reg_nxt; // waiting character
  logic tx_holding_empty_r, tx_holding_empty_nxt; // holding is empty
  logic [7:0] ien_r, ien_nxt; // interrupt enables
  logic [7:0] lctl_r, lctl_nxt; // line control
  logic [7:0] mctl_r, mctl_nxt; // modem control
  logic [15:0] div_r, div_nxt; // divisor latches
  logic [7:0] rdata_r, rdata_nxt; // read data
  logic div_load; // divisor byte written
  logic hold_wr; // character written to holding

  // transmitter state
  uth_tx_state_type state_r, state_nxt; // sequence state
  logic [7:0] shift_r, shift_nxt; // shift register
  logic [2:0] bit_idx_r, bit_idx_nxt; // data bits sent
  logic [5:0] tick_cnt_r, tick_cnt_nxt; // ticks within bit
  logic par_r, par_nxt; // parity bit of the character
  logic out_r, out_nxt; // serial line flop
  logic load_shift; // holding to shifter transfer
  logic line_bit; // bit on the line this cycle
  logic [3:0] wlen; // word length in bits
  logic [5:0] stop_len; // stop time in ticks

  // data bits masked to the word length
  function automatic logic [7:0] wmask(input logic [7:0] d,
                                       input logic [3:0] len);
    logic [7:0] m;
    m = 8'hff >> (4'h8 - len);
    return d & m;
  endfunction
  // write decode: request passed in so callers stay sensitive to it
  function automatic logic hit(input uth_host_req_type req,
                               input logic [2:0] off);
    return req.wr && req.addr == off;
  endfunction
  assign wlen = UTH_WLEN_BASE + {2'b00, lctl_r[UTH_LC_WLEN_LO+:2]};
  assign hold_wr = hit(host_req, UTH_OFF_HOLD) && !lctl_r[UTH_LC_DLAB];
  assign div_load = (hit(host_req, UTH_OFF_HOLD)
                    || hit(host_req, UTH_OFF_IEN)) && lctl_r[UTH_LC_DLAB];
  // stop time from line control, 1.5 only for 5-bit words
  always_comb begin
    if (!lctl_r[UTH_LC_STOP]) begin
      stop_len = UTH_TICKS_BIT; // see RQ3
    end else if (lctl_r[UTH_LC_WLEN_LO+:2] == 2'b00) begin
      stop_len = UTH_TICKS_STOP15;
    end else begin
      stop_len = UTH_TICKS_STOP2;
    end
  end

  // register writes and reads
  always_comb begin
    scratchpad_nxt = scratchpad_r;
    ien_nxt = ien_r;
    lctl_nxt = lctl_r;
    mctl_nxt = mctl_r;
    div_nxt = div_r;
    tx_holding_reg_nxt = tx_holding_reg_r;
    rdata_nxt = rdata_r;
    if (hit(host_req, UTH_OFF_SCRATCH)) begin
      scratchpad_nxt = host_req.wdata; // see RQ1
    end
    if (hit(host_req, UTH_OFF_LCTL)) begin
      lctl_nxt = host_req.wdata;
    end
    if (hit(host_req, UTH_OFF_MCTL)) begin
      mctl_nxt = host_req.wdata;
    end
    if (hold_wr) begin
      tx_holding_reg_nxt = host_req.wdata;
    end
    if (hit(host_req, UTH_OFF_IEN) && !lctl_r[UTH_LC_DLAB]) begin
      ien_nxt = host_req.wdata;
    end
    if (div_load && host_req.addr == UTH_OFF_HOLD) begin
      div_nxt[7:0] = host_req.wdata;
    end
    if (div_load && host_req.addr == UTH_OFF_IEN) begin
      div_nxt[15:8] = host_req.wdata;
    end
    if (host_req.rd) begin
      case (host_req.addr)
        UTH_OFF_HOLD: begin
          rdata_nxt = lctl_r[UTH_LC_DLAB] ? div_r[7:0] : UTH_RST_BYTE;
        end
        UTH_OFF_IEN: begin
          rdata_nxt = lctl_r[UTH_LC_DLAB] ? div_r[15:8] : ien_r;
        end
        UTH_OFF_LCTL: begin
          rdata_nxt = lctl_r;
        end
        UTH_OFF_MCTL: begin
          rdata_nxt = mctl_r;
        end
        UTH_OFF_LSTAT: begin
          rdata_nxt = UTH_RST_BYTE;
          rdata_nxt[UTH_LS_TX_HOLDING_EMPTY] = tx_holding_empty_r;
          rdata_nxt[UTH_LS_TEMT] = tx_holding_empty_r
                                   && state_r == UTH_ST_IDLE;
        end
        UTH_OFF_SCRATCH: begin
          rdata_nxt = scratchpad_r; // see RQ1
        end
        default: begin
          rdata_nxt = UTH_RST_BYTE; // unmapped reads zero
        end
      endcase
    end
  end

  // bit on the line for the current state
  always_comb begin
    case (state_r)
      UTH_ST_START: line_bit = 1'b0; // see RQ11
      UTH_ST_DATA: line_bit = shift_r[0]; // see RQ5
      UTH_ST_PARITY: line_bit = par_r;
      default: line_bit = 1'b1; // idle and stop are high
    endcase
  end

  // transmitter sequence, advanced only on baud ticks except when leaving idle
  always_comb begin
    state_nxt = state_r;
    shift_nxt = shift_r;
    bit_idx_nxt = bit_idx_r;
    tick_cnt_nxt = tick_cnt_r;
    par_nxt = par_r;
    load_shift = 1'b0;
    tx_holding_empty_nxt = tx_holding_empty_r;
    case (state_r)
      UTH_ST_IDLE: begin
        if (!tx_holding_empty_r) begin
          load_shift = 1'b1; // see RQ4
          shift_nxt = wmask(tx_holding_reg_r, wlen);
          par_nxt = lctl_r[UTH_LC_STICK] ? !lctl_r[UTH_LC_EVEN]
                  : (lctl_r[UTH_LC_EVEN] ? ^wmask(tx_holding_reg_r, wlen)
                  : ~^wmask(tx_holding_reg_r, wlen));
          tx_holding_empty_nxt = 1'b1;
          tick_cnt_nxt = 6'h00;
          bit_idx_nxt = 3'h0;
          state_nxt = UTH_ST_START;
        end
      end
      UTH_ST_START, UTH_ST_DATA, UTH_ST_PARITY: begin
        if (baud_tick_clock) begin // see RQ2
          tick_cnt_nxt = tick_cnt_r + 6'h01;
          if (tick_cnt_r == UTH_TICKS_BIT - 6'h01) begin // see RQ8
            tick_cnt_nxt = 6'h00;
            if (state_r == UTH_ST_START) begin
              state_nxt = UTH_ST_DATA;
            end else if (state_r == UTH_ST_PARITY) begin
              state_nxt = UTH_ST_STOP;
            end else begin
              shift_nxt = shift_r >> 1; // lsb first, see RQ5
              bit_idx_nxt = bit_idx_r + 3'h1;
              if ({1'b0, bit_idx_r} == wlen - 4'h1) begin
                state_nxt = lctl_r[UTH_LC_PEN] ? UTH_ST_PARITY
                          : UTH_ST_STOP; // see RQ3
              end
            end
          end
        end
      end
      UTH_ST_STOP: begin
        if (baud_tick_clock) begin
          tick_cnt_nxt = tick_cnt_r + 6'h01;
          if (tick_cnt_r == stop_len - 6'h01) begin
            tick_cnt_nxt = 6'h00;
            state_nxt = UTH_ST_IDLE;
          end
        end
      end
      default: begin
        state_nxt = UTH_ST_IDLE; // recover from a bad code
      end
    endcase
    if (hold_wr) begin
      tx_holding_empty_nxt = 1'b0; // new character wins, see RQ7
    end
    // loop forces the pin high, break forces it low
    out_nxt = mctl_r[UTH_MC_LOOP] ? 1'b1 // see RQ10
            : (lctl_r[UTH_LC_BREAK] ? 1'b0 : line_bit);
  end

  // register all state
  always_ff @(posedge clk) begin
    if (reset) begin
      scratchpad_r <= UTH_RST_BYTE;
      tx_holding_reg_r <= UTH_RST_BYTE;
      tx_holding_empty_r <= 1'b1;
      ien_r <= UTH_RST_BYTE;
      lctl_r <= UTH_RST_BYTE;
      mctl_r <= UTH_RST_BYTE;
      div_r <= UTH_RST_DIV;
      rdata_r <= UTH_RST_BYTE;
      state_r <= UTH_ST_IDLE;
      shift_r <= UTH_RST_BYTE;
      bit_idx_r <= 3'h0;
      tick_cnt_r <= 6'h00;
      par_r <= 1'b0;
      out_r <= 1'b1;
    end else begin
      scratchpad_r <= scratchpad_nxt;
      tx_holding_reg_r <= tx_holding_reg_nxt;
      tx_holding_empty_r <= tx_holding_empty_nxt;
      ien_r <= ien_nxt;
      lctl_r <= lctl_nxt;
      mctl_r <= mctl_nxt;
      div_r <= div_nxt;
      rdata_r <= rdata_nxt;
      state_r <= state_nxt;
      shift_r <= shift_nxt;
      bit_idx_r <= bit_idx_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      par_r <= par_nxt;
      out_r <= out_nxt;
    end
  end

  // baud divider, reloaded with the new divisor including the byte being written
  uth_baud_gen u_baud (
    .clk(clk),
    .reset(reset),
    .load(div_load), // see RQ9
    .divisor(div_nxt),
    .tick(baud_tick_clock)
  );
  assign rdata = rdata_r;
  assign serial_out = out_r;
  assign loop_data = mctl_r[UTH_MC_LOOP] & line_bit; // see RQ10
  assign tx_empty_irq = tx_holding_empty_r && ien_r[UTH_IE_TX_HOLDING_EMPTY]; // see RQ6
  chk_scratch_readback: assert property (@(posedge clk) // see RQ1
    disable iff (reset) (hit(host_req, UTH_OFF_SCRATCH)
      ##1 (host_req.rd && !host_req.wr && host_req.addr == UTH_OFF_SCRATCH))
    |=> rdata == $past(host_req.wdata, 2))
    else $error("scratchpad did not read back");
  chk_moves_on_tick: assert property (@(posedge clk) // see RQ2
    disable iff (reset) ($changed(state_r) && $past(state_r) != UTH_ST_IDLE)
    |-> $past(baud_tick_clock))
    else $error("transmitter advanced without a baud tick");
  chk_parity_gate: assert property (@(posedge clk) // see RQ3
    disable iff (reset) $rose(state_r == UTH_ST_PARITY) |-> lctl_r[UTH_LC_PEN])
    else $error("parity sent while parity disabled");
  chk_load_idle: assert property (@(posedge clk) // see RQ4
    disable iff (reset) load_shift
    |-> state_r == UTH_ST_IDLE ##1 state_r == UTH_ST_START)
    else $error("holding moved while shifter busy");
  chk_start_low: assert property (@(posedge clk) // see RQ11
    disable iff (reset) (state_r == UTH_ST_START && !mctl_r[UTH_MC_LOOP]
      && !lctl_r[UTH_LC_BREAK]) |=> !serial_out)
    else $error("start bit not low");
  chk_irq_raise: assert property (@(posedge clk) // see RQ6
    disable iff (reset) (load_shift && ien_r[UTH_IE_TX_HOLDING_EMPTY] && !hold_wr
      && !hit(host_req, UTH_OFF_IEN)) |=> tx_empty_irq)
    else $error("empty interrupt missing after transfer");
  chk_irq_clear: assert property (@(posedge clk) // see RQ7
    disable iff (reset) hold_wr |=> !tx_empty_irq ##1 (state_r != UTH_ST_IDLE
      || !tx_holding_empty_r || hold_wr))
    else $error("interrupt not cleared by a loaded character");
  chk_sixteen_ticks: assert property (@(posedge clk) // see RQ8
    disable iff (reset) (state_r == UTH_ST_DATA && $changed(bit_idx_r))
    |-> $past(tick_cnt_r) == UTH_TICKS_BIT - 6'h01)
    else $error("data bit not sixteen ticks long");
  chk_loop_high: assert property (@(posedge clk) // see RQ10
    disable iff (reset) mctl_r[UTH_MC_LOOP] |=> serial_out)
    else $error("serial line not held high in loop");
  chk_stop_high: assert property (@(posedge clk) // see RQ11
    disable iff (reset) (state_r == UTH_ST_STOP && !mctl_r[UTH_MC_LOOP]
      && !lctl_r[UTH_LC_BREAK]) |=> serial_out)
    else $error("stop bit not high");
endmodule

// *** testbench/uth_line_model.sv ***
// far side model: a serial receiver decoding frames from the tx line
`timescale 1ns/1ps
module uth_line_model (
  input wire logic clk, // system clock
  input wire logic reset, // synchronous, active high
  input wire logic tick, // 16x baud enable
  input wire logic line, // serial line watched
  input wire logic [7:0] lctl, // frame format in use
  output logic got, // one-cycle pulse, frame received
  output logic [7:0] data, // received data bits
  output logic ok // start, parity and stop levels right
);
  logic par; // running parity of data bits
  int nb; // data bits in this frame
  // waits for n baud ticks, marks the frame bad if ticks stop
  task automatic ticks(input int n);
    int w;
    repeat (n) begin
      w = 0;
      do begin
        @(posedge clk);
        w++;
      end while (tick !== 1'b1 && w < 1000);
      if (tick !== 1'b1) ok = 1'b0;
    end
  endtask
  // receiver: hunt for a start edge, then sample mid bit
  initial begin
    got = 1'b0;
    data = 8'h00;
    ok = 1'b0;
    forever begin
      @(posedge clk);
      if (reset === 1'b0 && line === 1'b0) begin // low start
        ok = 1'b1;
        ticks(8); // middle of start bit
        ok = ok & (line === 1'b0);
        nb = 5 + lctl[1:0];
        data = 8'h00;
        par = 1'b0;
        for (int i = 0; i < nb; i++) begin // lsb first
          ticks(16); // 16 ticks a bit
          data[i] = line;
          par = par ^ line;
        end
        if (lctl[3]) begin // parity bit
          ticks(16);
          ok = ok & (line === (lctl[5] ? !lctl[4] : (lctl[4] ? par : !par)));
        end
        ticks(16);
        ok = ok & (line === 1'b1); // stop high
        got = 1'b1;
        @(posedge clk);
        got = 1'b0;
      end
    end
  end
endmodule

// *** testbench/uth_tx_holding_bench.sv ***
// testbench of the tx holding path: registers, frames, irq, loop mode
`timescale 1ns/1ps
module uth_tx_holding_bench;
  import uth_pkg::*;
  logic clk = 1'b0; // 250 MHz clock
  logic reset = 1'b1; // synchronous reset
  uth_host_req_type host_req = '0; // register access
  logic [7:0] rdata; // read data
  logic serial_out; // tx line
  logic loop_data; // loop path
  logic baud_tick_clock; // 16x enable
  logic tx_empty_irq; // holding-empty irq
  logic loop_on = 1'b0; // model watches loop path
  logic [7:0] lctl_m = 8'h00; // format told to model
  logic got; // model frame pulse
  logic ok; // model frame check
  logic [7:0] rx; // model data
  logic rd_seen = 1'b0; // read taken last edge
  logic [7:0] v; // random data
  logic [7:0] lc; // line control value
  int lows = 0; // low cycles of tx line
  int mismatches = 0;
  int checked = 0;
  logic [15:0] exp_rd [$]; // {mask, value}
  logic [7:0] exp_ch [$]; // expected characters
  always #2 clk = ~clk;
  uth_tx_holding dut (
    .clk(clk),
    .reset(reset),
    .host_req(host_req),
    .rdata(rdata),
    .serial_out(serial_out),
    .loop_data(loop_data),
    .baud_tick_clock(baud_tick_clock),
    .tx_empty_irq(tx_empty_irq)
  );
  uth_line_model far (
    .clk(clk),
    .reset(reset),
    .tick(baud_tick_clock),
    .line(loop_on ? loop_data : serial_out),
    .lctl(lctl_m),
    .got(got),
    .data(rx),
    .ok(ok)
  );
  // verdict and end of run
  task report_and_stop;
    if (mismatches == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task bad(input string m);
    mismatches++;
    $display("BAD %0t %s", $time, m);
  endtask
  task cmp_rd(input logic [7:0] g, input logic [15:0] e);
    checked++;
    if ((g & e[15:8]) !== e[7:0]) bad("read data");
  endtask
  task cmp_ch(input logic [7:0] g, input logic k, input logic [7:0] e);
    checked++;
    if (g !== e || k !== 1'b1) bad("frame");
  endtask
  task cmp_bit(input logic g, input logic e, input string m);
    checked++;
    if (g !== e) bad(m);
  endtask
  // one request for one cycle, driven at the falling edge
  task op(input logic w, input logic r, input logic [2:0] a,
          input logic [7:0] d);
    @(negedge clk);
    host_req = '{wr: w, rd: r, addr: a, wdata: d};
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    op(1'b1, 1'b0, a, d);
  endtask
  task rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
    exp_rd.push_back({m, e});
    op(1'b0, 1'b1, a, 8'h00);
  endtask
  task idle;
    op(1'b0, 1'b0, 3'h0, 8'h00);
  endtask
  task send(input logic [7:0] d, input logic [7:0] e);
    exp_ch.push_back(e);
    wr(UTH_OFF_HOLD, d);
  endtask
  // waits until every expected frame arrived, counting line lows
  task wait_frames;
    lows = 0;
    for (int n = 0; n < 20000 && exp_ch.size() > 0; n++) begin
      @(negedge clk);
      if (serial_out !== 1'b1) lows++;
    end
    if (exp_ch.size() > 0) begin
      bad("frame timeout");
      report_and_stop;
    end
  endtask
  // first tick within lim cycles, then spacing of e cycles
  task tick_gap(input int lim, input int e);
    int n;
    n = 0;
    while (baud_tick_clock !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    cmp_bit(n <= lim, 1'b1, "first tick late");
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (baud_tick_clock !== 1'b1 && n < 300);
    cmp_bit(n == e, 1'b1, "tick spacing");
    if (n >= 300) report_and_stop;
  endtask
  // result watcher: read data one cycle after the read, frames
  always @(posedge clk) rd_seen <= host_req.rd;
  always @(negedge clk) begin
    if (rd_seen === 1'b1) cmp_rd(rdata, exp_rd.pop_front());
    if (got === 1'b1) begin
      if (exp_ch.size() == 0) bad("extra frame");
      else cmp_ch(rx, ok, exp_ch.pop_front());
    end
  end
  // main sequence
  initial begin
    void'($urandom(32'hcfce50b4));
    repeat (10) @(negedge clk);
    reset = 1'b0;
    cmp_bit(serial_out, 1'b1, "idle line");
    cmp_bit(tx_empty_irq, 1'b0, "irq after reset");
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      wr(UTH_OFF_SCRATCH, v);
      rd(UTH_OFF_SCRATCH, v, 8'hff);
    end
    wr(3'h2, 8'hff);
    rd(3'h2, 8'h00, 8'hff);
    rd(3'h6, 8'h00, 8'hff);
    rd(UTH_OFF_HOLD, 8'h00, 8'hff);
    wr(UTH_OFF_LCTL, 8'h80);
    wr(UTH_OFF_HOLD, 8'hc8);
    wr(UTH_OFF_IEN, 8'h00);
    wr(UTH_OFF_HOLD, 8'h03); // new divisor reloads at once
    wr(UTH_OFF_LCTL, 8'h03);
    idle;
    tick_gap(8, 3);
    wr(UTH_OFF_LCTL, 8'h80);
    wr(UTH_OFF_HOLD, 8'h02);
    rd(UTH_OFF_HOLD, 8'h02, 8'hff);
    wr(UTH_OFF_LCTL, 8'h03);
    lctl_m = 8'h03;
    idle;
    tick_gap(8, 2);
    wr(UTH_OFF_IEN, 8'h02);
    rd(UTH_OFF_IEN, 8'h02, 8'hff);
    idle;
    idle;
    cmp_bit(tx_empty_irq, 1'b1, "irq not raised");
    send(8'h3c, 8'h3c);
    idle;
    send(8'ha5, 8'ha5);
    repeat (4) idle;
    cmp_bit(tx_empty_irq, 1'b0, "irq not cleared");
    rd(UTH_OFF_LSTAT, 8'h00, 8'h60);
    wr(UTH_OFF_SCRATCH, 8'h5a);
    rd(UTH_OFF_SCRATCH, 8'h5a, 8'hff);
    idle;
    wait_frames;
    repeat (40) idle;
    cmp_bit(tx_empty_irq, 1'b1, "irq after drain");
    rd(UTH_OFF_LSTAT, 8'h60, 8'h60);
    wr(UTH_OFF_IEN, 8'h00);
    idle;
    idle;
    cmp_bit(tx_empty_irq, 1'b0, "irq disabled");
    for (int f = 0; f < 12; f++) begin
      v = $urandom;
      lc = {2'b00, 2'($urandom), f[2], 1'($urandom), f[1:0]};
      wr(UTH_OFF_LCTL, lc);
      lctl_m = lc;
      send(v, v & (8'hff >> (2'd3 - lc[1:0])));
      idle;
      wait_frames;
      repeat (80) idle;
    end
    wr(UTH_OFF_LCTL, 8'h03);
    lctl_m = 8'h03;
    wr(UTH_OFF_MCTL, 8'h10);
    idle;
    idle;
    loop_on = 1'b1;
    send(8'h96, 8'h96);
    idle;
    wait_frames;
    cmp_bit(lows == 0, 1'b1, "line low in loop");
    wr(UTH_OFF_MCTL, 8'h00);
    wr(UTH_OFF_LCTL, 8'h43); // break forces the line low
    idle;
    idle;
    cmp_bit(serial_out, 1'b0, "break not low");
    idle;
    report_and_stop;
  end
endmodule
